// >>> hw/sysref_sync_pkg.sv
package sysref_sync_pkg;

  localparam int CLK_MHZ = 125;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_IRQ_ENABLE  = 10'h020;
  localparam logic [9:0] IDX_IRQ_STAT0   = 10'h024;
  localparam logic [9:0] IDX_IRQ_STAT3   = 10'h027;
  localparam logic [9:0] IDX_IRQ_MUX_JIT = 10'h028;
  localparam logic [9:0] IDX_IRQ_MUX_PLL = 10'h02b;
  localparam logic [9:0] IDX_SUMMARY     = 10'h02c;
  localparam logic [9:0] IDX_SKIP_COUNT  = 10'h036;
  localparam logic [9:0] IDX_JIT_WINDOW  = 10'h039;
  localparam logic [9:0] IDX_SYNC_MODE   = 10'h03a;
  localparam logic [9:0] IDX_ROTATION    = 10'h03b;
  localparam logic [9:0] IDX_OSC_SYNC    = 10'h1e7;

  // event bits, shared by enable and status registers
  localparam int EV_PLL_LOCK = 0;
  localparam int EV_PLL_LOST = 1;
  localparam int EV_JITTER   = 2;
  localparam int EV_W        = 3;

  localparam int MUX_LOCK_BIT   = 0;
  localparam int MUX_LOST_BIT   = 1;
  localparam int MUX_JIT_BIT    = 4;
  localparam int SUMMARY_BIT    = 0;
  localparam int MODE_ONE_BIT   = 1;
  localparam int MODE_DONE_BIT  = 4;
  localparam int ROT_SYNC_BIT   = 7;
  localparam int ROT_PERIOD_BIT = 5;
  localparam int ROT_OSC_BIT    = 4;
  localparam int ROT_SOFT_BIT   = 1;
  localparam int ROT_SERDES_BIT = 0;
  localparam int OSC_SYNC_BIT   = 0;

  localparam logic [7:0] ROT_RESET    = 8'hb0;
  localparam logic [7:0] ROT_WMASK    = 8'hf3;
  localparam logic [7:0] SKIP_RESET   = 8'h00;
  localparam logic [6:0] WINDOW_RESET = 7'h00;

  // serdes clock reset pulse width
  localparam int SERDES_RST_NS  = 64;
  localparam int SERDES_RST_CYC = (SERDES_RST_NS * CLK_MHZ + 999) / 1000;

  localparam logic [7:0] GAIN_FULL = 8'hff;
  localparam logic [7:0] GAIN_STEP = 8'h11;

  typedef enum logic [1:0] {
    ROT_IDLE,
    ROT_FADE_OUT,
    ROT_APPLY,
    ROT_FADE_IN
  } rot_state_t;

endpackage

// >>> hw/edge_sync.sv
module edge_sync
  import sysref_sync_pkg::*;
#(
  parameter int W = 2
)(
  input  wire logic         ref_clk, // clock
  input  wire logic         sys_rst, // async reset
  input  wire logic [W-1:0] async_in, // pins
  output logic      [W-1:0] level, // synchronised level
  output logic      [W-1:0] rise, // rising edge pulse
  output logic      [W-1:0] fall // falling edge pulse
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_state_t;

  sync_state_t st_q;
  sync_state_t st_d;

  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign level = st_q.s2;
  assign rise  = st_q.s2 & ~st_q.s3;
  assign fall  = ~st_q.s2 & st_q.s3;

endmodule

// >>> hw/gain_ramp.sv
module gain_ramp
  import sysref_sync_pkg::*;
(
  input  wire logic       ref_clk, // clock
  input  wire logic       sys_rst, // async reset
  input  wire logic       fade_out, // 1 ramps down, 0 ramps up
  output logic      [7:0] gain, // datapath gain
  output logic            at_zero, // gain fully off
  output logic            at_full // gain fully on
);

  typedef struct packed {
    logic [7:0] gain;
  } ramp_state_t;

  ramp_state_t st_q;
  ramp_state_t st_d;

  always_comb
  begin
    st_d = st_q;
    if (fade_out)
      st_d.gain = (st_q.gain > GAIN_STEP) ? st_q.gain - GAIN_STEP : 8'h00;
    else if (st_q.gain < GAIN_FULL - GAIN_STEP)
      st_d.gain = st_q.gain + GAIN_STEP;
    else
      st_d.gain = GAIN_FULL;
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      st_q.gain <= GAIN_FULL;
    else
      st_q <= st_d;
  end

  assign gain    = st_q.gain;
  assign at_zero = (st_q.gain == 8'h00);
  assign at_full = (st_q.gain == GAIN_FULL);

endmodule

// >>> hw/sysref_sync_rotation_irq.sv
// Operation
// - enabled pll loss event goes to pin a when select is 0, else pin b
// - enabled pll lock event goes to pin a when select is 0, else pin b
// - summary bit is the OR of all interrupt status bits
// - writing one to summary bit clears all latched status bits
// - skip a programmed 8-bit count of sysref rising edges before syncing
// - 7-bit jitter tolerance in clocks; larger edge variation raises interrupt
// - read-only rotation done flag, one after reset
// - one-shot clear means monitor mode, flagging edges outside window
// - one-shot set syncs once on the edge after the skip count, then returns to monitor
// - bit 4 resets oscillators after reset or as rotation enters apply; sync start also
// - rotation mode bit 0 resets and realigns serdes clocks
// - rotation mode bit 1 ramps datapath gain off and on
// - rotation mode zero touches neither serdes clocks nor datapath
// - mode 1 drops links and resets serdes clocks
// - mode 2 switches datapath stream off and on around rotation
// - mode 3 does both serdes reset and datapath soft off/on
module sysref_sync_rotation_irq
  import sysref_sync_pkg::*;
#(
  parameter int PERIOD_W = 16
)(
  input  wire logic        ref_clk, // clock, 125 MHz
  input  wire logic        sys_rst, // async reset, active high
  input  wire logic [11:0] paddr, // apb byte address
  input  wire logic        psel, // apb select
  input  wire logic        penable, // apb enable
  input  wire logic        pwrite, // apb direction
  input  wire logic [31:0] pwdata, // apb write data
  output logic      [31:0] prdata, // apb read data
  output logic             pready, // apb ready
  output logic             pslverr, // apb error, unmapped
  input  wire logic        sysref, // sysref pin
  input  wire logic        pll_locked, // pll lock level
  output logic             interrupt_pin_a, // interrupt pin a
  output logic             interrupt_pin_b, // interrupt pin b
  output logic             serdes_clk_reset, // serdes clocks reset
  output logic      [7:0]  datapath_gain, // datapath gain
  output logic             osc_reset, // oscillator reset pulse
  output logic             rotation_busy // rotation in progress
);

  typedef struct packed {
    logic [EV_W-1:0]     irq_en;
    logic [EV_W-1:0]     stat;
    logic                mux_jit;
    logic [1:0]          mux_pll;
    logic [7:0]          skip_cfg;
    logic [6:0]          window;
    logic                oneshot;
    logic                mode_rsvd;
    logic [7:0]          rot_cfg;
    logic [7:0]          edge_cnt;
    logic [PERIOD_W-1:0] period;
    logic [PERIOD_W-1:0] ref_period;
    logic                edge_seen;
    logic                ref_valid;
    rot_state_t          rot_state;
    logic [7:0]          rot_cnt;
    logic                done;
    logic                serdes_rst;
    logic                osc_rst;
    logic                boot_done;
    logic [31:0]         rdata;
  } main_state_t;

  main_state_t st_q;
  main_state_t st_d;

  logic [1:0]          pin_level;
  logic [1:0]          pin_rise;
  logic [1:0]          pin_fall;
  logic [7:0]          gain;
  logic                gain_zero;
  logic                gain_full;
  logic [9:0]          idx;
  logic                setup;
  logic                wr;
  logic [EV_W-1:0]     ev_set;
  logic [EV_W-1:0]     ev_clr;
  logic [PERIOD_W-1:0] diff;
  logic                sync_on;
  logic                start_rot;
  logic                ramp_down;

  function automatic logic reg_hit(input logic [9:0] i);
    reg_hit = (i == IDX_IRQ_ENABLE) ||
              (i >= IDX_IRQ_STAT0 && i <= IDX_IRQ_MUX_JIT) ||
              (i == IDX_IRQ_MUX_PLL) || (i == IDX_SUMMARY) ||
              (i == IDX_SKIP_COUNT) || (i == IDX_JIT_WINDOW) ||
              (i == IDX_SYNC_MODE) || (i == IDX_ROTATION) ||
              (i == IDX_OSC_SYNC);
  endfunction

  function automatic logic [7:0] reg_read(input logic [9:0] i,
                                          input main_state_t s);
    reg_read = 8'h00;
    unique case (i)
      IDX_IRQ_ENABLE:  reg_read = {5'h00, s.irq_en};
      IDX_IRQ_STAT0:   reg_read = {5'h00, s.stat};
      IDX_IRQ_MUX_JIT: reg_read = {3'h0, s.mux_jit, 4'h0};
      IDX_IRQ_MUX_PLL: reg_read = {6'h00, s.mux_pll};
      IDX_SUMMARY:     reg_read = {7'h00, |s.stat};
      IDX_SKIP_COUNT:  reg_read = s.skip_cfg;
      IDX_JIT_WINDOW:  reg_read = {1'b0, s.window};
      IDX_SYNC_MODE:
        reg_read = {3'h0, s.done, 2'h0, s.oneshot, s.mode_rsvd};
      IDX_ROTATION:    reg_read = s.rot_cfg;
      default:         reg_read = 8'h00;
    endcase
  endfunction

  // sysref and pll lock come from outside this clock
  edge_sync #(
    .W (2)
  ) u_pins (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .async_in ({pll_locked, sysref}),
    .level    (pin_level),
    .rise     (pin_rise),
    .fall     (pin_fall)
  );

  gain_ramp u_ramp (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .fade_out (ramp_down),
    .gain     (gain),
    .at_zero  (gain_zero),
    .at_full  (gain_full)
  );

  assign idx     = paddr[11:2];
  assign setup   = psel & ~penable;
  assign wr      = psel & penable & pwrite & reg_hit(idx);
  assign pready  = psel & penable;
  assign pslverr = psel & penable & ~reg_hit(idx);
  assign sync_on = st_q.rot_cfg[ROT_SYNC_BIT];

  // gain stays off through apply, else samples leak mid-rotation
  assign ramp_down = (st_q.rot_state == ROT_FADE_OUT) |
                     ((st_q.rot_state == ROT_APPLY) &
                      st_q.rot_cfg[ROT_SOFT_BIT]);

  assign diff = (st_q.period >= st_q.ref_period) ?
                st_q.period - st_q.ref_period :
                st_q.ref_period - st_q.period;

  // pulse counting: the first edge beyond the skip count triggers
  assign start_rot = sync_on & st_q.oneshot & pin_rise[0] &
                     (st_q.rot_state == ROT_IDLE) &
                     (st_q.edge_cnt == st_q.skip_cfg);

  always_comb
  begin
    st_d = st_q;
    ev_set = '0;
    ev_clr = '0;
    st_d.osc_rst = 1'b0;

    // events latch only while enabled
    ev_set[EV_PLL_LOCK] = pin_rise[1] & st_q.irq_en[EV_PLL_LOCK];
    ev_set[EV_PLL_LOST] = pin_fall[1] & st_q.irq_en[EV_PLL_LOST];

    // edge spacing monitor
    if (st_q.period != '1)
      st_d.period = st_q.period + 1'b1;
    if (pin_rise[0])
    begin
      st_d.period    = '0;
      st_d.edge_seen = 1'b1;
      if (st_q.edge_seen && !st_q.ref_valid)
      begin
        st_d.ref_period = st_q.period;
        st_d.ref_valid  = 1'b1;
      end
      if (sync_on && !st_q.oneshot && st_q.ref_valid &&
          diff > {{(PERIOD_W-7){1'b0}}, st_q.window})
        ev_set[EV_JITTER] = st_q.irq_en[EV_JITTER];
    end

    if (sync_on && st_q.oneshot && pin_rise[0] &&
        st_q.rot_state == ROT_IDLE && !start_rot)
      st_d.edge_cnt = st_q.edge_cnt + 8'h01;

    // oscillator reset once after reset release
    if (!st_q.boot_done)
    begin
      st_d.boot_done = 1'b1;
      st_d.osc_rst   = st_q.rot_cfg[ROT_OSC_BIT];
    end

    unique case (st_q.rot_state)
      ROT_IDLE:
        if (start_rot)
        begin
          st_d.oneshot   = 1'b0;
          st_d.edge_cnt  = 8'h00;
          st_d.done      = 1'b0;
          st_d.ref_valid = 1'b0;
          st_d.edge_seen = 1'b0;
          st_d.rot_cnt   = 8'(SERDES_RST_CYC - 1);
          if (st_q.rot_cfg[ROT_SOFT_BIT])
            st_d.rot_state = ROT_FADE_OUT;
          else
          begin
            st_d.rot_state = ROT_APPLY;
            st_d.osc_rst   = st_q.rot_cfg[ROT_OSC_BIT];
          end
        end
      ROT_FADE_OUT:
        if (gain_zero)
        begin
          st_d.rot_state = ROT_APPLY;
          st_d.osc_rst   = st_q.rot_cfg[ROT_OSC_BIT];
        end
      ROT_APPLY:
        if (st_q.rot_cnt != 8'h00)
          st_d.rot_cnt = st_q.rot_cnt - 8'h01;
        else if (st_q.rot_cfg[ROT_SOFT_BIT])
          st_d.rot_state = ROT_FADE_IN;
        else
        begin
          st_d.rot_state = ROT_IDLE;
          st_d.done      = 1'b1;
        end
      ROT_FADE_IN:
        if (gain_full)
        begin
          st_d.rot_state = ROT_IDLE;
          st_d.done      = 1'b1;
        end
    endcase

    // serdes reset only in mode bit 0, nothing in mode zero
    st_d.serdes_rst = (st_d.rot_state == ROT_APPLY) &
                      st_q.rot_cfg[ROT_SERDES_BIT];

    // register writes
    if (wr)
    begin
      unique case (idx)
        IDX_IRQ_ENABLE:  st_d.irq_en = pwdata[EV_W-1:0];
        IDX_IRQ_STAT0:   ev_clr = pwdata[EV_W-1:0];
        IDX_IRQ_MUX_JIT: st_d.mux_jit = pwdata[MUX_JIT_BIT];
        IDX_IRQ_MUX_PLL: st_d.mux_pll = pwdata[1:0];
        IDX_SUMMARY:
          if (pwdata[SUMMARY_BIT])
            ev_clr = '1;
        IDX_SKIP_COUNT:
        begin
          st_d.skip_cfg = pwdata[7:0];
          st_d.edge_cnt = 8'h00;
        end
        IDX_JIT_WINDOW:  st_d.window = pwdata[6:0];
        IDX_SYNC_MODE:
        begin
          if (!start_rot)
            st_d.oneshot = pwdata[MODE_ONE_BIT];
          st_d.mode_rsvd = pwdata[0];
          st_d.edge_cnt  = 8'h00;
        end
        IDX_ROTATION:    st_d.rot_cfg = pwdata[7:0] & ROT_WMASK;
        IDX_OSC_SYNC:
          st_d.osc_rst = st_d.osc_rst | pwdata[OSC_SYNC_BIT];
        default:         st_d.rot_cfg = st_q.rot_cfg;
      endcase
    end

    // a new event wins over a clear in the same cycle
    st_d.stat = (st_q.stat & ~ev_clr) | ev_set;

    if (setup)
      st_d.rdata = {24'h000000, reg_read(idx, st_q)};
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_q           <= '0;
      st_q.skip_cfg  <= SKIP_RESET;
      st_q.window    <= WINDOW_RESET;
      st_q.rot_cfg   <= ROT_RESET;
      st_q.rot_state <= ROT_IDLE;
      st_q.done      <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  always_comb
  begin
    interrupt_pin_a = 1'b0;
    interrupt_pin_b = 1'b0;
    if (st_q.stat[EV_PLL_LOST] && st_q.irq_en[EV_PLL_LOST])
    begin
      if (st_q.mux_pll[MUX_LOST_BIT])
        interrupt_pin_b = 1'b1;
      else
        interrupt_pin_a = 1'b1;
    end
    if (st_q.stat[EV_PLL_LOCK] && st_q.irq_en[EV_PLL_LOCK])
    begin
      if (st_q.mux_pll[MUX_LOCK_BIT])
        interrupt_pin_b = 1'b1;
      else
        interrupt_pin_a = 1'b1;
    end
    if (st_q.stat[EV_JITTER] && st_q.irq_en[EV_JITTER])
    begin
      if (st_q.mux_jit)
        interrupt_pin_b = 1'b1;
      else
        interrupt_pin_a = 1'b1;
    end
  end

  assign prdata           = st_q.rdata;
  assign serdes_clk_reset = st_q.serdes_rst;
  assign osc_reset        = st_q.osc_rst;
  assign datapath_gain    = gain;
  assign rotation_busy    = (st_q.rot_state != ROT_IDLE);

endmodule

// >>> verification/sysref_sync_properties.sv
module sysref_sync_properties
(
  input logic       ref_clk, // clock
  input logic       sys_rst, // reset
  input logic       psel, // apb select
  input logic       penable, // apb enable
  input logic       pwrite, // apb direction
  input logic       sysref, // ref pin
  input logic       interrupt_pin_a, // pin a
  input logic       interrupt_pin_b, // pin b
  input logic       serdes_clk_reset, // serdes reset
  input logic [7:0] datapath_gain, // gain
  input logic       osc_reset, // osc reset
  input logic       rotation_busy // busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  chk_serdes_in_rot:
    assert property (serdes_clk_reset |-> rotation_busy)
    else $error("serdes reset outside rotation");
  chk_serdes_width:
    assert property ($rose(serdes_clk_reset) |->
      serdes_clk_reset [*8] ##1 !serdes_clk_reset)
    else $error("serdes reset width wrong");
  chk_gain_in_rot:
    assert property (datapath_gain != 8'hff |-> rotation_busy)
    else $error("gain moved outside rotation");
  chk_gain_step:
    assert property ($changed(datapath_gain) |->
      8'($past(datapath_gain) - datapath_gain) == 8'h11 ||
      8'(datapath_gain - $past(datapath_gain)) == 8'h11)
    else $error("gain step wrong");
  chk_osc_pulse:
    assert property (osc_reset |=> !osc_reset)
    else $error("osc reset longer than one cycle");
  chk_busy_start:
    assert property ($rose(rotation_busy) |->
      $past(sysref, 2) && $past(sysref, 3))
    else $error("rotation without ref edge");
  chk_busy_bound:
    assert property ($rose(rotation_busy) |-> ##[8:60] !rotation_busy)
    else $error("rotation length wrong");
  chk_pin_clear:
    assert property ($fell(interrupt_pin_a) || $fell(interrupt_pin_b)
      |-> $past(psel && penable && pwrite))
    else $error("pin fell without write");

  cover property ($rose(serdes_clk_reset));
  cover property (datapath_gain == 8'h00);
  cover property ($rose(interrupt_pin_b));
endmodule

// >>> verification/sysref_source.sv
module sysref_source
(
  input  logic ref_clk, // clock
  output logic sysref, // ref pulses
  output logic pll_locked // lock level
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    sysref = 1'b0;
    pll_locked = 1'b0;
  end
  // low for gap cycles, then high for 8
  task automatic pulse(input int gap);
    repeat (gap) @(posedge ref_clk);
    sysref <= 1'b1;
    repeat (8) @(posedge ref_clk);
    sysref <= 1'b0;
  endtask
  task automatic set_lock(input logic v);
    @(posedge ref_clk);
    pll_locked <= v;
  endtask
endmodule

// >>> verification/tb.sv
module tb
  import sysref_sync_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        sys_rst;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, rerr;
  logic        sysref, pll_locked, osc_reset, rotation_busy;
  logic        interrupt_pin_a, interrupt_pin_b, serdes_clk_reset;
  logic [7:0]  datapath_gain, min_g;
  logic        seen_s, seen_o, seen_b;
  int          num_errors = 0;
  int          samples_checked = 0;

  always #4 ref_clk = ~ref_clk;

  sysref_sync_rotation_irq i_sysref_sync_rotation_irq (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysref(sysref), .pll_locked(pll_locked),
    .interrupt_pin_a(interrupt_pin_a), .interrupt_pin_b(interrupt_pin_b),
    .serdes_clk_reset(serdes_clk_reset), .datapath_gain(datapath_gain),
    .osc_reset(osc_reset), .rotation_busy(rotation_busy));
  sysref_source src (
    .ref_clk(ref_clk), .sysref(sysref), .pll_locked(pll_locked));

  // record rotation side effects
  always @(posedge ref_clk)
  begin
    if (serdes_clk_reset === 1'b1) seen_s <= 1'b1;
    if (osc_reset === 1'b1) seen_o <= 1'b1;
    if (rotation_busy === 1'b1) seen_b <= 1'b1;
    if (datapath_gain < min_g) min_g <= datapath_gain;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pins(input logic [1:0] exp);
    check({30'h0, interrupt_pin_b, interrupt_pin_a}, {30'h0, exp});
  endtask
  task automatic apb(input logic [9:0] idx, input logic w,
                     input logic [7:0] wd);
    psel <= 1'b1;
    paddr <= {idx, 2'b00};
    pwrite <= w;
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    apb(idx, 1'b1, d);
  endtask
  task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
    apb(idx, 1'b0, 8'h00);
    check(rdata, {24'h0, exp});
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    stop_test();
  end

  initial
  begin
    sys_rst <= 1'b1;
    paddr <= 12'h000;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    pwdata <= 32'h0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    rd(IDX_ROTATION, ROT_RESET);
    rd(IDX_SYNC_MODE, 8'h10);
    rd(IDX_SUMMARY, 8'h00);
    rd(IDX_SKIP_COUNT, SKIP_RESET);
    rd(IDX_JIT_WINDOW, 8'h00);
    wr(IDX_SKIP_COUNT, 8'ha5);
    rd(IDX_SKIP_COUNT, 8'ha5);
    wr(IDX_JIT_WINDOW, 8'hff);
    rd(IDX_JIT_WINDOW, 8'h7f);
    wr(IDX_ROTATION, 8'hff);
    rd(IDX_ROTATION, ROT_WMASK);
    apb(10'h001, 1'b0, 8'h00);
    check({31'h0, rerr}, 32'h1);
    // monitor mode: reference period 40, window 2
    wr(IDX_ROTATION, 8'hf0);
    wr(IDX_JIT_WINDOW, 8'h02);
    wr(IDX_IRQ_ENABLE, 8'h04);
    repeat (3) src.pulse(32);
    src.pulse(34);
    src.pulse(32);
    chk_pins(2'b00);
    src.pulse(35);
    repeat (6) @(posedge ref_clk);
    chk_pins(2'b01);
    rd(IDX_IRQ_STAT0, 8'h04);
    wr(IDX_IRQ_MUX_JIT, 8'h10);
    chk_pins(2'b10);
    wr(IDX_SUMMARY, 8'h01);
    chk_pins(2'b00);
    // pll events
    wr(IDX_IRQ_ENABLE, 8'h03);
    src.set_lock(1'b1);
    repeat (6) @(posedge ref_clk);
    chk_pins(2'b01);
    rd(IDX_IRQ_STAT0, 8'h01);
    rd(IDX_SUMMARY, 8'h01);
    wr(IDX_IRQ_MUX_PLL, 8'h01);
    chk_pins(2'b10);
    wr(IDX_SUMMARY, 8'h01);
    chk_pins(2'b00);
    rd(IDX_SUMMARY, 8'h00);
    src.set_lock(1'b0);
    repeat (6) @(posedge ref_clk);
    chk_pins(2'b01);
    wr(IDX_IRQ_MUX_PLL, 8'h02);
    chk_pins(2'b10);
    wr(IDX_IRQ_STAT0, 8'h02);
    chk_pins(2'b00);
    // one-shot rotation in every mode, two edges skipped
    for (logic [7:0] m = 8'h00; m < 8'h04; m++)
    begin
      wr(IDX_ROTATION, (m[0] ? 8'he0 : 8'hf0) | m);
      wr(IDX_SKIP_COUNT, 8'h02);
      wr(IDX_SYNC_MODE, 8'h02);
      seen_s = 1'b0;
      seen_o = 1'b0;
      seen_b = 1'b0;
      min_g = 8'hff;
      repeat (2) src.pulse(10);
      check({31'h0, seen_b}, 32'h0);
      fork
        src.pulse(10);
      join_none
      while (rotation_busy !== 1'b1)
        @(posedge ref_clk);
      rd(IDX_SYNC_MODE, 8'h00);
      while (rotation_busy === 1'b1)
        @(posedge ref_clk);
      check({29'h0, seen_o, seen_s, min_g == 8'h00},
            {29'h0, ~m[0], m[0], m[1]});
      rd(IDX_SYNC_MODE, 8'h10);
      seen_b = 1'b0;
      src.pulse(10);
      repeat (6) @(posedge ref_clk);
      check({31'h0, seen_b}, 32'h0);
    end
    // software sync start pulses the oscillator reset
    seen_o = 1'b0;
    wr(IDX_OSC_SYNC, 8'h01);
    @(posedge ref_clk);
    check({31'h0, seen_o}, 32'h1);
    stop_test();
  end
endmodule

bind sysref_sync_rotation_irq sysref_sync_properties i_props (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .sysref(sysref),
  .interrupt_pin_a(interrupt_pin_a), .interrupt_pin_b(interrupt_pin_b),
  .serdes_clk_reset(serdes_clk_reset), .datapath_gain(datapath_gain),
  .osc_reset(osc_reset), .rotation_busy(rotation_busy));
